/* rtl/sts_fifo.sv */
// Purpose: small byte FIFO between the fetch port and the shifter
// Assumes: DEPTH is a power of two
// Notes: flush empties it at once
`timescale 1ns/1ns
module sts_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] cnt_ff;
	logic push;
	logic pop;

	assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem_ff[rd_ff];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else if (flush) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff <= wr_ff + AW'(push);
			rd_ff <= rd_ff + AW'(pop);
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : sts_fifo

/* rtl/sts_pkg.sv */
// Purpose: constants and types for the serial slave transmit buffer block
// Assumes: REF_CLK at 10 MHz, register bus byte addresses
// Notes: control and status words at 0x5F0 and 0x5F4 release and watch the buffers
package sts_pkg;
	localparam int ADDR_W = 12;
	localparam int CNT_W = 15;
	localparam int FIFO_DEPTH = 8;
	localparam logic [11:0] OFS_TX_PTR = 12'h544;
	localparam logic [11:0] OFS_TX_MAX = 12'h548;
	localparam logic [11:0] OFS_TX_AMOUNT = 12'h54C;
	localparam logic [11:0] OFS_TX_LIST = 12'h550;
	localparam logic [11:0] OFS_CONFIG = 12'h554;
	localparam logic [11:0] OFS_DEF_CHAR = 12'h55C;
	localparam logic [11:0] OFS_ORC_CHAR = 12'h5C0;
	localparam logic [11:0] OFS_CTRL = 12'h5F0;
	localparam logic [11:0] OFS_STATUS = 12'h5F4;
	localparam int CTRL_RELEASE_BIT = 0;
	localparam int CTRL_ACQUIRE_BIT = 1;
	localparam int STAT_GRANT_BIT = 0;
	localparam int STAT_ACTIVE_BIT = 1;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [CNT_W-1:0] RST_CNT = 15'h0000;
	localparam logic [7:0] RST_CHAR = 8'h00;
	localparam int CLK_KHZ = 10000;
	localparam int T_START_NS = 125;
	localparam int START_CYC_RAW = (T_START_NS * CLK_KHZ) / 1000000;
	localparam int START_CYC = (START_CYC_RAW < 1) ? 1 : START_CYC_RAW;
	typedef struct packed {
		logic csn_n;
		logic sck;
	} sts_link_t;
	localparam sts_link_t LINK_IDLE = '{csn_n: 1'b1, sck: 1'b0};
	typedef enum logic [1:0] {ST_IDLE, ST_BUF, ST_IGN} sts_xfer_t;
endpackage : sts_pkg

/* rtl/sts_shifter.sv */
// Purpose: mode 0 output shifter, msb first
// Assumes: rise and fall are one-cycle pulses of the synchronised clock
// Notes: a load replaces the shift on a byte boundary
`timescale 1ns/1ns
module sts_shifter (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// link events
	input wire logic start,
	input wire logic rise,
	input wire logic fall,
	// byte supply
	input wire logic load,
	input wire logic [7:0] load_byte,
	// state
	output logic bit_out,
	output logic boundary,
	output logic byte_done
);
	import sts_pkg::*;
	logic [7:0] sr_ff;
	logic [2:0] cnt_ff;

	assign bit_out = sr_ff[7];
	assign boundary = (cnt_ff == 3'h0);
	assign byte_done = rise & (cnt_ff == 3'h7);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sr_ff <= RST_CHAR;
		end else if (load) begin
			sr_ff <= load_byte;
		end else if (fall) begin
			sr_ff <= {sr_ff[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 3'h0;
		end else if (start) begin
			cnt_ff <= 3'h0;
		end else if (rise) begin
			cnt_ff <= cnt_ff + 3'h1;
		end
	end
endmodule : sts_shifter

/* rtl/sts_top.sv */
// Purpose: transmit buffer registers and fill characters of a serial slave
// Assumes: mode 0 link, SCK far slower than REF_CLK; fetch port on REF_CLK
// Notes: one fetch outstanding at a time; FIFO back-pressure stalls fetching
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ns
module sts_top (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// register bus
	input wire logic [sts_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// buffer fetch port
	output logic RD_REQ,
	output logic [31:0] RD_ADDR,
	input wire logic RD_ACK,
	input wire logic [7:0] RD_DATA,
	// serial link
	input wire logic SCK,
	input wire logic CSN_N,
	output logic MISO,
	output logic MISO_OE
);
	import sts_pkg::*;

	function automatic logic [31:0] be_merge(input logic [31:0] old,
			input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return res;
	endfunction : be_merge

	// link synchroniser
	sts_link_t s1_ff;
	sts_link_t s2_ff;
	sts_link_t s3_ff;
	logic sck_rise;
	logic sck_fall;
	logic csn_fall;
	logic csn_rise;

	// bus slave
	logic ack_ff;
	logic wr_do;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;

	// registers
	logic [31:0] ptr_ff;
	logic [CNT_W-1:0] max_ff;
	logic [CNT_W-1:0] amount_ff;
	logic [31:0] list_ff;
	logic [31:0] config_ff;
	logic [7:0] def_ff;
	logic [7:0] orc_ff;
	logic [31:0] m_max;
	logic [31:0] m_def;
	logic [31:0] m_orc;
	logic release_do;
	logic acquire_do;
	logic grant_ff;

	// fetch and transaction
	logic req_ff;
	logic stale_ff;
	logic [31:0] rd_addr_ff;
	logic [CNT_W-1:0] fetched_ff;
	logic fetch_ok;
	logic push;
	logic fifo_in_ready;
	logic fifo_valid;
	logic [7:0] fifo_data;
	sts_xfer_t state_ff;
	logic granted_now;
	logic [CNT_W-1:0] loaded_ff;
	logic [CNT_W-1:0] base_cnt;
	logic [CNT_W-1:0] done_ff;
	logic cur_buf_ff;
	logic load;
	logic use_buf;
	logic [7:0] nxt_byte;
	logic boundary;
	logic byte_done;
	logic bit_out;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			s1_ff <= LINK_IDLE;
			s2_ff <= LINK_IDLE;
			s3_ff <= LINK_IDLE;
		end else begin
			s1_ff <= '{csn_n: CSN_N, sck: SCK};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// edges are taken from the second and third stage only
	assign sck_rise = s2_ff.sck & ~s3_ff.sck & ~s2_ff.csn_n;
	assign sck_fall = ~s2_ff.sck & s3_ff.sck & ~s2_ff.csn_n;
	assign csn_fall = ~s2_ff.csn_n & s3_ff.csn_n;
	assign csn_rise = s2_ff.csn_n & ~s3_ff.csn_n;

	// every access answers at the second edge; one wait cycle keeps reads registered
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_ff;
	assign AVS_READDATA = rdata_ff;
	assign wr_do = AVS_WRITE & ack_ff;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (AVS_READ | AVS_WRITE) & ~ack_ff;
		end
	end

	always_comb begin
		case (AVS_ADDRESS)
			OFS_TX_PTR: nxt_rdata = ptr_ff;
			OFS_TX_MAX: nxt_rdata = {17'h0_0000, max_ff};
			OFS_TX_AMOUNT: nxt_rdata = {17'h0_0000, amount_ff};
			OFS_TX_LIST: nxt_rdata = list_ff;
			OFS_CONFIG: nxt_rdata = config_ff;
			OFS_DEF_CHAR: nxt_rdata = {24'h00_0000, def_ff};
			OFS_ORC_CHAR: nxt_rdata = {24'h00_0000, orc_ff};
			OFS_STATUS: nxt_rdata = {30'h0000_0000, state_ff != ST_IDLE, grant_ff};
			default: nxt_rdata = RST_WORD;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_ff <= RST_WORD;
		end else if (AVS_READ & ~ack_ff) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign m_max = be_merge({17'h0_0000, max_ff}, AVS_WRITEDATA, AVS_BYTEENABLE);
	assign m_def = be_merge({24'h00_0000, def_ff}, AVS_WRITEDATA, AVS_BYTEENABLE);
	assign m_orc = be_merge({24'h00_0000, orc_ff}, AVS_WRITEDATA, AVS_BYTEENABLE);

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ptr_ff <= RST_WORD;
			max_ff <= RST_CNT;
			list_ff <= RST_WORD;
			config_ff <= RST_WORD;
			def_ff <= RST_CHAR;
			orc_ff <= RST_CHAR;
		end else if (wr_do) begin
			case (AVS_ADDRESS)
				OFS_TX_PTR: ptr_ff <= be_merge(ptr_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
				OFS_TX_MAX: max_ff <= m_max[CNT_W-1:0];
				OFS_TX_LIST: list_ff <= be_merge(list_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
				OFS_CONFIG: config_ff <= be_merge(config_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
				OFS_DEF_CHAR: def_ff <= m_def[7:0];
				OFS_ORC_CHAR: orc_ff <= m_orc[7:0];
				default: ;
			endcase
		end
	end

	assign release_do = wr_do & (AVS_ADDRESS == OFS_CTRL) & AVS_BYTEENABLE[0]
		& AVS_WRITEDATA[CTRL_RELEASE_BIT];
	assign acquire_do = wr_do & (AVS_ADDRESS == OFS_CTRL) & AVS_BYTEENABLE[0]
		& AVS_WRITEDATA[CTRL_ACQUIRE_BIT];

	// software cannot take the buffers back in the middle of a granted transaction
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			grant_ff <= 1'b0;
		end else if (release_do) begin
			grant_ff <= 1'b1;
		end else if (acquire_do && state_ff != ST_BUF) begin
			grant_ff <= 1'b0;
		end else if (csn_rise && state_ff == ST_BUF) begin
			grant_ff <= 1'b0;
		end
	end

	// fetching stops at the byte limit, so the buffer is never read past it
	// no new fetch in the release cycle: its address would belong to the old buffer
	assign fetch_ok = grant_ff & ~req_ff & ~release_do & (fetched_ff < max_ff)
		& fifo_in_ready;
	assign push = RD_ACK & req_ff & ~stale_ff & grant_ff;
	assign RD_REQ = req_ff;
	assign RD_ADDR = rd_addr_ff;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			req_ff <= 1'b0;
			rd_addr_ff <= RST_WORD;
		end else if (fetch_ok) begin
			req_ff <= 1'b1;
			rd_addr_ff <= ptr_ff + {17'h0_0000, fetched_ff};
		end else if (RD_ACK) begin
			req_ff <= 1'b0;
		end
	end

	// an answer to a fetch issued before a new release belongs to the old buffer
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			stale_ff <= 1'b0;
		end else if (release_do && req_ff && !RD_ACK) begin
			stale_ff <= 1'b1;
		end else if (RD_ACK) begin
			stale_ff <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			fetched_ff <= RST_CNT;
		end else if (release_do) begin
			fetched_ff <= RST_CNT;
		end else if (fetch_ok) begin
			fetched_ff <= fetched_ff + 15'h0001;
		end
	end

	sts_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.flush(release_do),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(RD_DATA),
		.out_valid(fifo_valid),
		.out_ready(load & use_buf),
		.out_data(fifo_data)
	);

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_ff <= ST_IDLE;
		end else if (csn_fall) begin
			state_ff <= grant_ff ? ST_BUF : ST_IGN;
		end else if (csn_rise) begin
			state_ff <= ST_IDLE;
		end
	end

	assign granted_now = (state_ff == ST_BUF) | (csn_fall & grant_ff);
	assign load = csn_fall | (sck_fall & boundary & (state_ff != ST_IDLE));
	// a new frame counts from zero, not from the total of the frame before
	assign base_cnt = csn_fall ? RST_CNT : loaded_ff;

	// an empty FIFO inside the limit also sends the over-read character
	always_comb begin
		use_buf = 1'b0;
		nxt_byte = def_ff;
		if (granted_now) begin
			if (base_cnt < max_ff && fifo_valid) begin
				use_buf = 1'b1;
				nxt_byte = fifo_data;
			end else begin
				nxt_byte = orc_ff;
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			loaded_ff <= RST_CNT;
			cur_buf_ff <= 1'b0;
		end else if (load) begin
			loaded_ff <= base_cnt + CNT_W'(use_buf);
			cur_buf_ff <= use_buf;
		end
	end

	// only bytes whose eighth bit went out count as sent
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			done_ff <= RST_CNT;
		end else if (csn_fall) begin
			done_ff <= RST_CNT;
		end else if (byte_done && cur_buf_ff && state_ff == ST_BUF) begin
			done_ff <= done_ff + 15'h0001;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			amount_ff <= RST_CNT;
		end else if (csn_rise && state_ff == ST_BUF) begin
			amount_ff <= done_ff;
		end
	end

	sts_shifter u_shift (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.start(csn_fall),
		.rise(sck_rise),
		.fall(sck_fall),
		.load(load),
		.load_byte(nxt_byte),
		.bit_out(bit_out),
		.boundary(boundary),
		.byte_done(byte_done)
	);

	assign MISO = bit_out;
	assign MISO_OE = ~s2_ff.csn_n;

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);

	sequence s_ptr_write;
		wr_do && AVS_ADDRESS == OFS_TX_PTR && AVS_BYTEENABLE == 4'hF;
	endsequence
	sequence s_release;
		release_do;
	endsequence
	sequence s_ignored_start;
		csn_fall && !grant_ff;
	endsequence
	sequence s_overread_load;
		load && granted_now && base_cnt >= max_ff;
	endsequence
	sequence s_granted_end;
		csn_rise && state_ff == ST_BUF;
	endsequence

	AST_PTR_WRITE: assert property (s_ptr_write |=> ptr_ff == $past(AVS_WRITEDATA))
		else $error("pointer write not stored");
	AST_MAX_LIMIT: assert property ((load && use_buf) |-> base_cnt < max_ff)
		else $error("buffer byte sent beyond limit");
	AST_AMOUNT_SET: assert property (s_granted_end |=> amount_ff == $past(done_ff))
		else $error("sent count not captured at end");
	AST_DEF_FILL: assert property (s_ignored_start |=> MISO == $past(def_ff[7]))
		else $error("ignored transaction not sending default character");
	AST_ORC_FILL: assert property (s_overread_load |=> MISO == $past(orc_ff[7]))
		else $error("over-read not sending over-read character");
	AST_START_TIME: assert property (s_release |=> grant_ff ##1 grant_ff || csn_rise)
		else $error("buffers not handed over in time");
	AST_AMOUNT_HOLD: assert property (!(csn_rise && state_ff == ST_BUF) |=> $stable(amount_ff))
		else $error("sent count changed outside transaction end");
endmodule : sts_top

/* verif/sts_spi_master.sv */
// Purpose: mode 0 serial master model that clocks bytes out of the slave
// Assumes: bench clock of 100 ns, SCK period of 800 ns
// Notes: SCK rests low between frames; bytes seen on MISO are queued in got
`timescale 1ns/1ns
module sts_spi_master (
	// clock
	input wire logic clk,
	// link
	output logic sck,
	output logic csn_n,
	input wire logic miso
);
	logic [7:0] got[$];
	initial begin
		sck = 1'b0;
		csn_n = 1'b1;
	end
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : wait_cyc
	// 1000 ns setup and hold around SCK, gap above 300 ns between frames
	task automatic xfer(input int n);
		logic [7:0] b;
		got.delete();
		csn_n <= 1'b0;
		wait_cyc(10);
		for (int i = 0; i < n; i++) begin
			for (int k = 0; k < 8; k++) begin
				// sampled on the rising edge, msb first
				b = {b[6:0], miso};
				sck <= 1'b1;
				wait_cyc(4);
				sck <= 1'b0;
				wait_cyc(4);
			end
			got.push_back(b);
		end
		wait_cyc(10);
		csn_n <= 1'b1;
		wait_cyc(6);
	endtask : xfer
endmodule : sts_spi_master

/* verif/sts_top_tb_top.sv */
// Purpose: self-checking bench for the transmit buffer registers
// Assumes: bus answers within a few cycles; fetch port answered by a model memory
// Notes: memory byte is a fixed function of the address, so order is visible
`timescale 1ns/1ns
module sts_top_tb_top;
	import sts_pkg::*;
	logic REF_CLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
	logic RD_REQ, RD_ACK, SCK, CSN_N, MISO, MISO_OE;
	logic [ADDR_W-1:0] AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, RD_ADDR;
	logic [3:0] AVS_BYTEENABLE;
	logic [7:0] RD_DATA;
	int bad_count = 0;
	int checks_done = 0;
	int ack_count = 0;
	int ack_lat = 0;
	int lat_cnt = 0;
	sts_top sts_top_inst (.REF_CLK(REF_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .RD_REQ(RD_REQ), .RD_ADDR(RD_ADDR),
		.RD_ACK(RD_ACK), .RD_DATA(RD_DATA), .SCK(SCK), .CSN_N(CSN_N), .MISO(MISO),
		.MISO_OE(MISO_OE));
	sts_spi_master sts_spi_master_inst (.clk(REF_CLK), .sck(SCK), .csn_n(CSN_N), .miso(MISO));
	function automatic logic [7:0] mem_byte(input logic [31:0] a);
		return a[7:0] ^ 8'hA5;
	endfunction : mem_byte
	// memory answers after ack_lat cycles; data toggles when not valid
	always @(posedge REF_CLK) begin
		RD_ACK <= 1'b0;
		RD_DATA <= ~RD_DATA;
		if (RD_REQ === 1'b1 && RD_ACK === 1'b0) begin
			if (lat_cnt >= ack_lat) begin
				RD_ACK <= 1'b1;
				RD_DATA <= mem_byte(RD_ADDR);
				ack_count <= ack_count + 1;
				lat_cnt <= 0;
			end else begin
				lat_cnt <= lat_cnt + 1;
			end
		end
	end
	task automatic finish_test();
		if (bad_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	// one request, held until waitrequest is sampled low, then one idle edge
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		AVS_ADDRESS <= a;
		AVS_WRITE <= wr;
		AVS_READ <= ~wr;
		AVS_WRITEDATA <= d;
		AVS_BYTEENABLE <= 4'hF;
		do @(posedge REF_CLK); while (AVS_WAITREQUEST !== 1'b0);
		q = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		@(posedge REF_CLK);
	endtask : bus
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string n);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(n, q, exp);
	endtask : rd_chk
	task automatic t_reset();
		logic [11:0] ofs[5] = '{OFS_TX_PTR, OFS_TX_MAX, OFS_TX_AMOUNT, OFS_DEF_CHAR, OFS_ORC_CHAR};
		foreach (ofs[i]) rd_chk(ofs[i], RST_WORD, "reset value");
	endtask : t_reset
	task automatic t_regs();
		wr(OFS_TX_PTR, 32'h8000_10FE);
		wr(OFS_TX_MAX, 32'h0000_0003);
		wr(OFS_DEF_CHAR, 32'h1234_563C);
		wr(OFS_ORC_CHAR, 32'hFFFF_FFC3);
		wr(OFS_TX_AMOUNT, 32'h0000_0055);
		rd_chk(OFS_TX_PTR, 32'h8000_10FE, "pointer");
		rd_chk(OFS_TX_MAX, 32'h0000_0003, "limit");
		rd_chk(OFS_DEF_CHAR, 32'h0000_003C, "default char");
		rd_chk(OFS_ORC_CHAR, 32'h0000_00C3, "over-read char");
		rd_chk(OFS_TX_AMOUNT, 32'h0000_0000, "count read-only");
		rd_chk(12'h100, 32'h0000_0000, "unmapped");
	endtask : t_regs
	task automatic t_ignored();
		ack_count = 0;
		sts_spi_master_inst.xfer(2);
		foreach (sts_spi_master_inst.got[i]) chk("ignored byte", sts_spi_master_inst.got[i], 32'h0000_003C);
		rd_chk(OFS_TX_AMOUNT, 32'h0000_0000, "count after ignored");
		chk("fetches when ignored", ack_count, 32'h0000_0000);
	endtask : t_ignored
	task automatic t_granted();
		ack_count = 0;
		wr(OFS_CTRL, 32'h0000_0001);
		repeat (START_CYC) @(posedge REF_CLK);
		fork
			sts_spi_master_inst.xfer(5);
			begin
				repeat (8) @(posedge REF_CLK);
				chk("drive enable", MISO_OE, 32'h0000_0001);
			end
		join
		for (int i = 0; i < 5; i++) begin
			chk("granted byte", sts_spi_master_inst.got[i], (i < 3) ? mem_byte(32'h8000_10FE + i) : 8'hC3);
		end
		chk("drive enable off", MISO_OE, 32'h0000_0000);
		rd_chk(OFS_TX_AMOUNT, 32'h0000_0003, "count");
		chk("fetches", ack_count, 32'h0000_0003);
		rd_chk(OFS_STATUS, 32'h0000_0000, "grant returned");
	endtask : t_granted
	// buffer fills until it refuses while the link stalls, then drains empty
	task automatic t_fifo_full();
		wr(OFS_TX_PTR, 32'h0000_2000);
		wr(OFS_TX_MAX, 32'h0000_000C);
		ack_lat = 2;
		ack_count = 0;
		wr(OFS_CTRL, 32'h0000_0001);
		repeat (60) @(posedge REF_CLK);
		chk("fetches while stalled", ack_count, FIFO_DEPTH);
		rd_chk(OFS_TX_AMOUNT, 32'h0000_0003, "previous count");
		sts_spi_master_inst.xfer(12);
		for (int i = 0; i < 12; i++) begin
			chk("buffer byte", sts_spi_master_inst.got[i], mem_byte(32'h0000_2000 + i));
		end
		rd_chk(OFS_TX_AMOUNT, 32'h0000_000C, "full count");
		chk("all fetches", ack_count, 32'h0000_000C);
	endtask : t_fifo_full
	// release shows in status; take back returns the buffers outside a frame
	task automatic t_acquire();
		wr(OFS_CTRL, 32'h0000_0001);
		rd_chk(OFS_STATUS, 32'h0000_0001, "granted status");
		wr(OFS_CTRL, 32'h0000_0002);
		rd_chk(OFS_STATUS, 32'h0000_0000, "taken back");
	endtask : t_acquire
	initial begin
		REF_CLK = 1'b0;
		forever #50 REF_CLK = ~REF_CLK;
	end
	initial begin
		RST_N = 1'b0;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_ADDRESS = 12'h000;
		AVS_WRITEDATA = 32'h0000_0000;
		AVS_BYTEENABLE = 4'hF;
		RD_ACK = 1'b0;
		RD_DATA = 8'h00;
		repeat (8) @(posedge REF_CLK);
		RST_N <= 1'b1;
		@(posedge REF_CLK);
		t_reset();
		t_regs();
		t_ignored();
		t_granted();
		t_fifo_full();
		t_acquire();
		finish_test();
	end
	// whole run is under two thousand cycles; this is more than ten times that
	initial begin
		#2000000;
		bad_count++;
		finish_test();
	end
endmodule : sts_top_tb_top
